// File: cst_consts.vh
// Constants for the carrier speed tachometer block
`ifndef CST_CONSTS_VH
`define CST_CONSTS_VH

// ****************************************
// Register indexes and byte addresses
// ****************************************
`define CST_IDX_PORT 8'h02
`define CST_IDX_STATUS 8'h03
`define CST_ADDR_PORT 8'h08
`define CST_ADDR_STATUS 8'h0C

// ****************************************
// Carrier port fields (host data bits 0..7)
// ****************************************
`define CST_BIT_HOLD 0
`define CST_BIT_UNDERLINE 1
`define CST_BIT_TEST_POINT 2
`define CST_BIT_INTERPOSER 3
`define CST_BIT_STANDBY 4
`define CST_BIT_GO_RIGHT 5
`define CST_BIT_HIGH_SPEED 6
`define CST_BIT_GO 7

// ****************************************
// Status fields
// ****************************************
`define CST_STAT_COUNT_LSB 0
`define CST_STAT_COUNT_MSB 7
`define CST_STAT_TC 8
`define CST_STAT_UNDERSPEED 9
`define CST_STAT_DECEL 10
`define CST_STAT_TRAVEL_RIGHT 11

// ****************************************
// Reset values and tachometer presets
// ****************************************
`define CST_PORT_RESET 8'h00
`define CST_COUNT_RESET 8'h00
`define CST_TICK_RESET 16'h0000
`define CST_PRDATA_RESET 32'h00000000
`define CST_PRESET_HIGH 8'h67
`define CST_PRESET_LOW 8'h2E
`define CST_TERMINAL 8'hFF

// ****************************************
// Timing: tachometer count clock
// ****************************************
`define CST_CLOCK_NS 25
`define CST_TACH_PERIOD_NS 3000
`define CST_TACH_DIV (`CST_TACH_PERIOD_NS / `CST_CLOCK_NS)

`endif

// File: cst_tachometer.v
// Carrier speed tachometer, drive gating and carrier port
//
// Operation
// - High-speed bit feeds counter preset data
// - Drive outputs purely gated port and tachometer
// - High-current enable is inverted hold bit
// - High-speed preset is 0110 0111
// - Carrier-go directly sets underspeed flop
// - Right drive: go-right, go, underspeed
// - Terminal count before edge keeps drive
// - Early window edge clears underspeed flop
// - Edge re-presets; terminal count restores drive
// - Falling high speed pulses, sets decel latch
// - Decel set, go-right low: drive left
// - Low-speed preset is 0010 1110
// - Same regulation mirrored for left travel
// - Port address 2 loads eight control bits
// - Encoder gives twenty windows per position
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "cst_consts.vh"

module cst_tachometer #(
   parameter TACH_DIV = `CST_TACH_DIV
) (
   // Clock and reset
   input wire i_clock,
   input wire i_reset,
   // APB slave
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [7:0] i_paddr,
   input wire [31:0] i_pwdata,
   output wire [31:0] o_prdata,
   output wire o_pready,
   output wire o_pslverr,
   // Encoder pin
   input wire i_print_window_edge,
   // Carrier port outputs
   output wire o_hold_solenoid_drive,
   output wire o_high_current_enable_n,
   output wire o_underline_pin_enable,
   output wire o_test_point,
   output wire o_interposer_drive,
   output wire o_standby_request,
   // Motor drive and tachometer state
   output wire o_drive_right_n,
   output wire o_drive_left_n,
   output wire o_terminal_count_flag,
   output wire o_decel_latch_out
);

   // ****************************************
   // Declarations
   // ****************************************
   reg [7:0] port_r;
   reg go_prev_r;
   reg hs_prev_r;
   reg [2:0] edge_sync_r;
   reg [15:0] tick_cnt_r;
   reg [7:0] count_r;
   reg underspeed_r;
   reg decel_r;
   reg travel_right_r;
   reg [31:0] prdata_r;
   reg [31:0] prdata_nxt;
   reg [7:0] port_nxt;
   reg [15:0] tick_cnt_nxt;
   reg [7:0] count_nxt;
   reg underspeed_nxt;
   reg decel_nxt;
   reg travel_right_nxt;
   wire go;
   wire go_right;
   wire high_speed;
   wire window_pulse;
   wire tick;
   wire tc;
   wire hs_fall;
   wire go_rise;
   wire drive_on;
   wire braking;
   wire setup_phase;
   wire access_phase;
   wire hit_port;
   wire hit_status;
   wire [7:0] preset;
   wire [31:0] status_word;
   wire [31:0] tick_last;

   // Port fields used by the tachometer
   assign go = port_r[`CST_BIT_GO];
   assign go_right = port_r[`CST_BIT_GO_RIGHT];
   assign high_speed = port_r[`CST_BIT_HIGH_SPEED];

   // ****************************************
   // APB slave
   // ****************************************
   assign setup_phase = i_psel & ~i_penable;
   assign access_phase = i_psel & i_penable;
   assign hit_port = (i_paddr == `CST_ADDR_PORT);
   assign hit_status = (i_paddr == `CST_ADDR_STATUS);
   assign o_pready = 1'b1;
   assign o_pslverr = access_phase & ~(hit_port | hit_status);

   // ****************************************
   // Read data
   // ****************************************
   assign status_word = {20'h00000, travel_right_r, decel_r,
      underspeed_r, tc, count_r};

   // Read data captured in setup phase, shown in access phase
   always @* begin
      prdata_nxt = prdata_r;
      if (setup_phase & ~i_pwrite) begin
         if (hit_port) begin
            prdata_nxt = {24'h000000, port_r};
         end else if (hit_status) begin
            prdata_nxt = status_word;
         end else begin
            prdata_nxt = 32'h00000000;
         end
      end
   end

   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         prdata_r <= `CST_PRDATA_RESET;
      end else begin
         prdata_r <= prdata_nxt;
      end
   end

   assign o_prdata = prdata_r;

   // ****************************************
   // Carrier port
   // ****************************************
   // Carrier port load from host write
   always @* begin
      port_nxt = port_r;
      if (access_phase & i_pwrite & hit_port) begin
         port_nxt = i_pwdata[7:0];
      end
   end

   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         port_r <= `CST_PORT_RESET;
      end else begin
         port_r <= port_nxt;
      end
   end

   assign o_hold_solenoid_drive = port_r[`CST_BIT_HOLD];
   assign o_high_current_enable_n = ~port_r[`CST_BIT_HOLD];
   assign o_underline_pin_enable = port_r[`CST_BIT_UNDERLINE];
   assign o_test_point = port_r[`CST_BIT_TEST_POINT];
   assign o_interposer_drive = port_r[`CST_BIT_INTERPOSER];
   assign o_standby_request = port_r[`CST_BIT_STANDBY];

   // ****************************************
   // Window edge synchroniser
   // ****************************************
   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         edge_sync_r <= 3'h0;
      end else begin
         edge_sync_r <= {edge_sync_r[1:0], i_print_window_edge};
      end
   end

   assign window_pulse = edge_sync_r[1] & ~edge_sync_r[2];

   // ****************************************
   // Count clock divider
   // ****************************************
   assign tick_last = TACH_DIV - 1;
   assign tick = (tick_cnt_r == tick_last[15:0]);

   always @* begin
      tick_cnt_nxt = tick_cnt_r + 16'h0001;
      if (window_pulse | tick) begin
         tick_cnt_nxt = 16'h0000;
      end
   end

   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         tick_cnt_r <= `CST_TICK_RESET;
      end else begin
         tick_cnt_r <= tick_cnt_nxt;
      end
   end

   // ****************************************
   // Tachometer counter
   // ****************************************
   // Preset chosen by the high-speed bit
   assign preset = high_speed ? `CST_PRESET_HIGH :
      `CST_PRESET_LOW;
   assign tc = (count_r == `CST_TERMINAL);
   assign o_terminal_count_flag = tc;

   always @* begin
      count_nxt = count_r;
      if (window_pulse) begin
         count_nxt = preset;
      end else if (tick & ~tc) begin
         count_nxt = count_r + 8'h01;
      end
   end

   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         count_r <= `CST_COUNT_RESET;
      end else begin
         count_r <= count_nxt;
      end
   end

   // ****************************************
   // Underspeed flop
   // ****************************************
   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         go_prev_r <= 1'b0;
         hs_prev_r <= 1'b0;
      end else begin
         go_prev_r <= go;
         hs_prev_r <= high_speed;
      end
   end

   assign go_rise = go & ~go_prev_r;

   // Set wins over the edge reset
   always @* begin
      underspeed_nxt = underspeed_r;
      if (go_rise) begin
         underspeed_nxt = 1'b1;
      end else if (tc) begin
         underspeed_nxt = 1'b1;
      end else if (window_pulse) begin
         underspeed_nxt = 1'b0;
      end
   end

   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         underspeed_r <= 1'b0;
      end else begin
         underspeed_r <= underspeed_nxt;
      end
   end

   // ****************************************
   // Deceleration latch
   // ****************************************
   assign hs_fall = hs_prev_r & ~high_speed;

   always @* begin
      decel_nxt = decel_r;
      travel_right_nxt = travel_right_r;
      if (go & hs_fall) begin
         decel_nxt = 1'b1;
         travel_right_nxt = go_right;
      end else if (~go) begin
         decel_nxt = 1'b0;
      end
   end

   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         decel_r <= 1'b0;
         travel_right_r <= 1'b0;
      end else begin
         decel_r <= decel_nxt;
         travel_right_r <= travel_right_nxt;
      end
   end

   assign o_decel_latch_out = decel_r;

   // ****************************************
   // Drive gating
   // ****************************************
   // Braking while direction opposes the travel at deceleration
   assign braking = decel_r & (go_right != travel_right_r);
   assign drive_on = underspeed_r | tc;

   assign o_drive_right_n = ~(go & go_right &
      (braking | drive_on));
   assign o_drive_left_n = ~(go & ~go_right &
      (braking | drive_on));

endmodule

// File: cst_checker.sv
// Assertion checker for the carrier speed tachometer
`timescale 1ns/100ps
module cst_checker (
   input wire i_clock, input wire i_reset,
   input wire i_psel, input wire i_penable, input wire i_pwrite,
   input wire [7:0] i_paddr, input wire [31:0] i_pwdata,
   input wire o_pslverr, input wire i_print_window_edge,
   input wire o_hold_solenoid_drive, input wire o_high_current_enable_n,
   input wire o_interposer_drive, input wire o_drive_right_n,
   input wire o_drive_left_n, input wire o_terminal_count_flag,
   input wire o_decel_latch_out
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_reset);
   chk_hicur_inv: assert property (
      o_high_current_enable_n != o_hold_solenoid_drive) else $error("hicur");
   chk_one_drive: assert property (
      o_drive_right_n || o_drive_left_n) else $error("both drives");
   chk_reset_idle: assert property (
      $fell(i_reset) |-> o_drive_right_n && o_drive_left_n &&
      !o_decel_latch_out) else $error("reset state");
   chk_port_write: assert property (
      i_psel && i_penable && i_pwrite && i_paddr == 8'h08 |=>
      o_hold_solenoid_drive == $past(i_pwdata[0]) &&
      o_interposer_drive == $past(i_pwdata[3])) else $error("port");
   chk_bad_addr: assert property (
      i_psel && i_penable |-> o_pslverr == (i_paddr != 8'h08 &&
      i_paddr != 8'h0C)) else $error("pslverr");
   chk_edge_preset: assert property (
      $rose(i_print_window_edge) |-> ##4 !o_terminal_count_flag)
      else $error("no preset");
   chk_tc_keep: assert property (
      o_terminal_count_flag && !i_print_window_edge &&
      !$past(i_print_window_edge) && !$past(i_print_window_edge, 2) &&
      !$past(i_print_window_edge, 3) |=> o_terminal_count_flag)
      else $error("tc lost");
   chk_tc_cause: assert property (
      $fell(o_terminal_count_flag) |-> $past(i_print_window_edge, 2) ||
      $past(i_print_window_edge, 3)) else $error("tc cleared");
endmodule
bind cst_tachometer cst_checker cst_checker_inst (.i_clock, .i_reset,
   .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pslverr,
   .i_print_window_edge, .o_hold_solenoid_drive, .o_high_current_enable_n,
   .o_interposer_drive, .o_drive_right_n, .o_drive_left_n,
   .o_terminal_count_flag, .o_decel_latch_out);

// File: cst_encoder.sv
// Encoder model driving the print window pin
`timescale 1ns/100ps
module cst_encoder (
   input wire i_clock,
   input wire i_fire,
   output wire o_pin
);
   logic [2:0] cnt_r = 3'h0;
   logic pin_r = 1'b0;
   assign o_pin = pin_r;
   // Window stays lit four clocks, dark otherwise
   always @(posedge i_clock) begin
      cnt_r <= i_fire ? 3'h4 : cnt_r - (cnt_r != 3'h0);
      pin_r <= i_fire || cnt_r > 3'h1;
   end
endmodule

// File: carrier_speed_tachometer_test.sv
// Testbench for the carrier speed tachometer
`timescale 1ns/100ps
module carrier_speed_tachometer_test;
   logic i_clock = 0, i_reset = 1, psel = 0, pen = 0, pwr = 0, fire = 0;
   logic [7:0] padr = 0;
   logic [31:0] pwd = 0, rd;
   logic er;
   wire [31:0] prd;
   wire rdy, err, pin, hold, hc_n, underline_pin_enable, tp, ip, sb, r_n, l_n, tc, dcl;
   int n_fail = 0, checks = 0, cyc = 0;
   cst_tachometer #(.TACH_DIV(4)) cst_tachometer_inst (.i_clock,
      .i_reset, .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(padr), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy),
      .o_pslverr(err), .i_print_window_edge(pin),
      .o_hold_solenoid_drive(hold), .o_high_current_enable_n(hc_n),
      .o_underline_pin_enable(underline_pin_enable), .o_test_point(tp),
      .o_interposer_drive(ip), .o_standby_request(sb),
      .o_drive_right_n(r_n), .o_drive_left_n(l_n),
      .o_terminal_count_flag(tc), .o_decel_latch_out(dcl));
   cst_encoder cst_encoder_inst (.i_clock, .i_fire(fire), .o_pin(pin));
   initial forever #12.5 i_clock = ~i_clock;
   task check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task end_sim;
      $display("checks %0d failures %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   always @(posedge i_clock) begin
      cyc++;
      if (cyc == 12000) begin
         n_fail++;
         end_sim;
      end
   end
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clock);
      psel <= 1'b1;
      pwr <= w;
      padr <= a;
      pwd <= d;
      @(posedge i_clock);
      pen <= 1'b1;
      do @(posedge i_clock); while (rdy !== 1'b1);
      rd = prd;
      er = err;
      psel <= 1'b0;
      pen <= 1'b0;
      #1;
   endtask
   task wait_n(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask
   task window;
      @(posedge i_clock);
      fire <= 1'b1;
      @(posedge i_clock);
      fire <= 1'b0;
      wait_n(6);
      apb(0, 8'h0C, 0);
   endtask
   task t_port;
      apb(1, 8'h08, 32'h1F);
      check({hold, hc_n, underline_pin_enable, tp, ip, sb}, 6'h2F);
      apb(0, 8'h08, 0);
      check(rd, 32'h1F);
      apb(0, 8'h10, 0);
      check({er, rd[30:0]}, 32'h8000_0000);
   endtask
   task t_right;
      apb(1, 8'h08, 32'hE9);
      wait_n(2);
      check({r_n, l_n}, 2'b01);
      window;
      check({r_n, rd[9], rd[7:0] - 8'h67 < 4}, 3'b101);
      wait_n(640);
      check({tc, r_n}, 2'b10);
   endtask
   task t_decel;
      apb(1, 8'h08, 32'hA9);
      wait_n(2);
      check({dcl, r_n}, 2'b10);
      apb(1, 8'h08, 32'h89);
      check({r_n, l_n}, 2'b10);
      window;
      check(rd[7:0] - 8'h2E < 4, 1);
      apb(1, 8'h08, 32'h88);
      check({hc_n, dcl, l_n}, 3'b110);
      wait_n(8);
      apb(1, 8'h08, 32'h08);
      wait_n(2);
      check({dcl, r_n, l_n}, 3'b011);
   endtask
   task t_left;
      apb(1, 8'h08, 32'h89);
      wait_n(2);
      check({r_n, l_n}, 2'b10);
      window;
      check({r_n, l_n}, 2'b11);
      apb(1, 8'h08, 32'hC9);
      apb(1, 8'h08, 32'h89);
      apb(1, 8'h08, 32'hA9);
      check({dcl, r_n, l_n}, 3'b101);
   endtask
   initial begin
      repeat (2) @(posedge i_clock);
      i_reset <= 1'b0;
      t_port;
      t_right;
      t_decel;
      t_left;
      @(posedge i_clock);
      i_reset <= 1'b1;
      wait_n(1);
      check({r_n, l_n, dcl, hold}, 4'hC);
      @(posedge i_clock);
      i_reset <= 1'b0;
      apb(0, 8'h08, 0);
      check(rd, 0);
      end_sim;
   end
endmodule
